// file: hw/tmr8sp_params.svh
`ifndef TMR8SP_PARAMS_SVH
`define TMR8SP_PARAMS_SVH

// Register byte addresses on the AXI4-Lite port
`define TMR8SP_OFF_COUNT      8'h00
`define TMR8SP_OFF_INTCTL     8'h04
`define TMR8SP_OFF_OPTION     8'h08
`define TMR8SP_OFF_IRQ_STAT   8'h0c
`define TMR8SP_OFF_IRQ_CLR    8'h10
`define TMR8SP_OFF_IRQ_EN     8'h14
`define TMR8SP_OFF_WDT_COUNT  8'h18

// Option register fields
`define TMR8SP_OPT_CS_BIT     5
`define TMR8SP_OPT_SE_BIT     4
`define TMR8SP_OPT_PSA_BIT    3
`define TMR8SP_OPT_PS_MSB     2
`define TMR8SP_OPT_RESET      8'hff

// Interrupt-control fields
`define TMR8SP_INT_IE_BIT     5
`define TMR8SP_INT_IF_BIT     2
`define TMR8SP_INT_RESET      8'h00

// Sticky event status bits
`define TMR8SP_EVT_OVF_BIT    0
`define TMR8SP_EVT_WDT_BIT    1
`define TMR8SP_EVT_W          2

// Timing
`define TMR8SP_PHASES         2'h3
`define TMR8SP_PH_Q2          2'h1
`define TMR8SP_PH_Q4          2'h3
`define TMR8SP_INHIBIT_CYC    2'h2

// AXI responses
`define TMR8SP_RESP_OKAY      2'h0
`define TMR8SP_RESP_DECERR    2'h3

`endif

// file: hw/tmr8sp_pkg.sv
package tmr8sp_pkg;
  // Write-side handshake state of the bus slave
  typedef enum logic [2:0] {
    TMR8SP_WR_IDLE = 3'h1,
    TMR8SP_WR_HALF = 3'h2,
    TMR8SP_WR_RESP = 3'h4
  } tmr8sp_wr_state_t;
  typedef logic [7:0] tmr8sp_byte_t;
endpackage

// file: hw/tmr8sp_top.sv
// Operation
// - 8-bit count register, software read and write
// - Timer mode counts every instruction cycle
// - Counting held off two cycles after write
// - Counter mode counts chosen edge on pin
// - Option bit 5 selects pin or cycle clock
// - Option bit 4: one falling, zero rising
// - One prescaler, timer or watchdog, bit 3
// - Rate code: timer 2..256, watchdog 1..128
// - Undivided timer only when watchdog owns prescaler
// - Prescaler hidden; count write clears it (here only while timer owns it)
// - Watchdog clear resets prescaler and watchdog (here prescaler only while watchdog owns it)
// - Wrap FFh to 00h always sets flag
// - Timer request needs flag and enable
// - Counter frozen in sleep
// - Counter mode sampled on phases two, four
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`include "tmr8sp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tmr8sp_top
  import tmr8sp_pkg::*;
(
  input  wire logic        aclk,                  // 250 MHz system clock
  input  wire logic        aresetn,               // Synchronous reset, low
  input  wire logic [7:0]  s_axi_awaddr,          // Write address
  input  wire logic        s_axi_awvalid,         // Write address valid
  output logic             s_axi_awready,         // Write address ready
  input  wire logic [31:0] s_axi_wdata,           // Write data
  input  wire logic [3:0]  s_axi_wstrb,           // Write byte strobes
  input  wire logic        s_axi_wvalid,          // Write data valid
  output logic             s_axi_wready,          // Write data ready
  output logic [1:0]       s_axi_bresp,           // Write response
  output logic             s_axi_bvalid,          // Write response valid
  input  wire logic        s_axi_bready,          // Write response ready
  input  wire logic [7:0]  s_axi_araddr,          // Read address
  input  wire logic        s_axi_arvalid,         // Read address valid
  output logic             s_axi_arready,         // Read address ready
  output logic [31:0]      s_axi_rdata,           // Read data
  output logic [1:0]       s_axi_rresp,           // Read response
  output logic             s_axi_rvalid,          // Read data valid
  input  wire logic        s_axi_rready,          // Read data ready
  input  wire logic        external_count_input,  // Count pin level
  input  wire logic        sleep_mode,            // Core asleep, high
  input  wire logic        watchdog_clock_tick,   // Watchdog oscillator pulse
  input  wire logic        watchdog_clear_instruction, // Watchdog clear pulse
  output logic             timer_irq_request,     // Flag and enable both set
  output logic             watchdog_timeout,      // Watchdog count wrap pulse
  output logic             irq                    // Enabled sticky status
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Last prescaler state before a tick: timer ratio is twice watchdog
  function automatic tmr8sp_byte_t rate_last(input logic [2:0] ps, input logic to_wdt);
    logic [8:0] ratio;
    ratio = to_wdt ? (9'h001 << ps) : (9'h002 << ps);
    return tmr8sp_byte_t'(ratio - 9'h001);
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  tmr8sp_byte_t          count_q;
  tmr8sp_byte_t          option_q;
  tmr8sp_byte_t          presc_q;
  tmr8sp_byte_t          wdt_q;
  logic                  ovf_flag_q;
  logic                  ovf_ie_q;
  logic [1:0]            phase_q;
  logic [1:0]            inhibit_q;
  logic                  pin_q;
  logic                  pend_q;
  logic [`TMR8SP_EVT_W-1:0] stat_q;
  logic [`TMR8SP_EVT_W-1:0] irq_en_q;
  tmr8sp_wr_state_t      wr_state_q;
  logic [7:0]            awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  aw_got_q;
  logic                  w_got_q;

  logic       cs;
  logic       se;
  logic       prescaler_assign;
  logic [2:0] ps;
  logic       q2;
  logic       q4;
  logic       instr_tick;
  logic       pin_edge;
  logic       presc_src;
  logic       presc_hit;
  logic       presc_clr;
  logic       timer_evt;
  logic       sample_ok;
  logic       inc_now;
  logic       ovf_evt;
  logic       wdt_evt;
  logic       wdt_wrap;
  logic       wr_fire;
  logic [7:0] wr_addr;
  logic       wr_lo;
  logic       wr_count;
  logic       wr_intctl;

  assign cs  = option_q[`TMR8SP_OPT_CS_BIT];
  assign se  = option_q[`TMR8SP_OPT_SE_BIT];
  assign prescaler_assign = option_q[`TMR8SP_OPT_PSA_BIT];
  assign ps  = option_q[`TMR8SP_OPT_PS_MSB:0];

  // ------------------------------------------------------------
  // Instruction cycle: four phases per cycle
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign q2         = phase_q == `TMR8SP_PH_Q2;
  assign q4         = phase_q == `TMR8SP_PH_Q4;
  assign instr_tick = q4 && !sleep_mode;  // One tick per instruction cycle

  // Pin taken as synchronous; keep last level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= external_count_input;
    end
  end

  // Only the polarity picked by the edge select counts
  assign pin_edge = se ? (pin_q && !external_count_input)
                       : (!pin_q && external_count_input);

  // ------------------------------------------------------------
  // Shared prescaler
  // ------------------------------------------------------------
  // Watchdog owner runs from its own oscillator even in sleep
  assign presc_src = prescaler_assign ? watchdog_clock_tick
                         : (!sleep_mode && (cs ? pin_edge : instr_tick));
  assign presc_hit = presc_src && (presc_q == rate_last(ps, prescaler_assign));
  assign presc_clr = (!prescaler_assign && wr_count) || (prescaler_assign && watchdog_clear_instruction);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 8'h00;
    end else if (presc_clr || presc_hit) begin
      presc_q <= 8'h00;
    end else if (presc_src) begin
      presc_q <= presc_q + 8'h01;
    end
  end

  // Timer takes undivided events only while the watchdog owns it
  assign timer_evt = prescaler_assign ? (!sleep_mode && (cs ? pin_edge : instr_tick)) : presc_hit;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  // Pin-driven events wait for the next phase-two or phase-four sample
  assign sample_ok = q2 || q4;
  assign inc_now   = (inhibit_q == 2'h0) && !sleep_mode && !wr_count &&
                     (cs ? ((pend_q || timer_evt) && sample_ok) : timer_evt);
  assign ovf_evt   = inc_now && (count_q == 8'hff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
    end else if (!cs || wr_count || inhibit_q != 2'h0 || sleep_mode) begin
      pend_q <= 1'b0;  // Events seen while held off are dropped
    end else if (sample_ok) begin
      pend_q <= 1'b0;
    end else if (timer_evt) begin
      pend_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 8'h00;
    end else if (wr_count) begin
      count_q <= wdata_q[7:0];
    end else if (inc_now) begin
      count_q <= count_q + 8'h01;
    end
  end

  // Hold-off ends at the second phase four after the write, five to eight clocks later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhibit_q <= 2'h0;
    end else if (wr_count) begin
      inhibit_q <= `TMR8SP_INHIBIT_CYC;
    end else if (q4 && inhibit_q != 2'h0) begin
      inhibit_q <= inhibit_q - 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Watchdog count (postscaler not modelled)
  // ------------------------------------------------------------
  assign wdt_evt  = prescaler_assign ? presc_hit : watchdog_clock_tick;
  assign wdt_wrap = wdt_evt && !watchdog_clear_instruction && (wdt_q == 8'hff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_q <= 8'h00;
    end else if (watchdog_clear_instruction) begin
      wdt_q <= 8'h00;
    end else if (wdt_evt) begin
      wdt_q <= wdt_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_timeout <= 1'b0;
    end else begin
      watchdog_timeout <= wdt_wrap;
    end
  end

  // ------------------------------------------------------------
  // Overflow flag and enable
  // ------------------------------------------------------------
  // Setting outranks a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag_q <= 1'b0;
      ovf_ie_q   <= 1'b0;
    end else begin
      if (ovf_evt) begin
        ovf_flag_q <= 1'b1;
      end else if (wr_intctl) begin
        ovf_flag_q <= wdata_q[`TMR8SP_INT_IF_BIT];
      end
      if (wr_intctl) begin
        ovf_ie_q <= wdata_q[`TMR8SP_INT_IE_BIT];
      end
    end
  end

  assign timer_irq_request = ovf_flag_q && ovf_ie_q;

  // ------------------------------------------------------------
  // Sticky status, clear and enable
  // ------------------------------------------------------------
  logic [`TMR8SP_EVT_W-1:0] evt_vec;
  logic [`TMR8SP_EVT_W-1:0] clr_vec;
  assign evt_vec = {wdt_wrap, ovf_evt};
  assign clr_vec = (wr_fire && wr_lo && addr_is(wr_addr, `TMR8SP_OFF_IRQ_CLR))
                 ? wdata_q[`TMR8SP_EVT_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr_vec) | evt_vec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= '0;
    end else if (wr_fire && wr_lo && addr_is(wr_addr, `TMR8SP_OFF_IRQ_EN)) begin
      irq_en_q <= wdata_q[`TMR8SP_EVT_W-1:0];
    end
  end

  assign irq = |(stat_q & irq_en_q);

  // ------------------------------------------------------------
  // AXI4-Lite write side
  // ------------------------------------------------------------
  assign s_axi_awready = (wr_state_q != TMR8SP_WR_RESP) && !aw_got_q;
  assign s_axi_wready  = (wr_state_q != TMR8SP_WR_RESP) && !w_got_q;
  assign wr_fire       = (wr_state_q == TMR8SP_WR_RESP) && !s_axi_bvalid;
  assign wr_addr       = awaddr_q;
  assign wr_lo         = wstrb_q[0];
  assign wr_count      = wr_fire && wr_lo && addr_is(wr_addr, `TMR8SP_OFF_COUNT);
  assign wr_intctl     = wr_fire && wr_lo && addr_is(wr_addr, `TMR8SP_OFF_INTCTL);

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= TMR8SP_WR_IDLE;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      awaddr_q   <= 8'h00;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
      end
      unique case (wr_state_q)
        TMR8SP_WR_IDLE, TMR8SP_WR_HALF: begin
          if ((aw_got_q || (s_axi_awvalid && s_axi_awready)) &&
              (w_got_q || (s_axi_wvalid && s_axi_wready))) begin
            wr_state_q <= TMR8SP_WR_RESP;
          end else if (s_axi_awvalid || s_axi_wvalid || aw_got_q || w_got_q) begin
            wr_state_q <= TMR8SP_WR_HALF;
          end
        end
        TMR8SP_WR_RESP: begin
          if (s_axi_bvalid && s_axi_bready) begin
            wr_state_q <= TMR8SP_WR_IDLE;
            aw_got_q   <= 1'b0;
            w_got_q    <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= TMR8SP_WR_IDLE;
        end
      endcase
    end
  end

  // Option register, written only by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_q <= `TMR8SP_OPT_RESET;
    end else if (wr_fire && wr_lo && addr_is(wr_addr, `TMR8SP_OFF_OPTION)) begin
      option_q <= wdata_q[7:0];
    end
  end

  // Response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TMR8SP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_addr <= `TMR8SP_OFF_WDT_COUNT && wr_addr[1:0] == 2'h0)
                    ? `TMR8SP_RESP_OKAY : `TMR8SP_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read side
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Prescaler value is never visible to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TMR8SP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `TMR8SP_RESP_OKAY;
      unique case (s_axi_araddr)
        `TMR8SP_OFF_COUNT:     s_axi_rdata <= {24'h0, count_q};
        `TMR8SP_OFF_INTCTL:    s_axi_rdata <= {26'h0, ovf_ie_q, 2'h0, ovf_flag_q, 2'h0};
        `TMR8SP_OFF_OPTION:    s_axi_rdata <= {24'h0, option_q};
        `TMR8SP_OFF_IRQ_STAT:  s_axi_rdata <= {30'h0, stat_q};
        `TMR8SP_OFF_IRQ_CLR:   s_axi_rdata <= 32'h0000_0000;
        `TMR8SP_OFF_IRQ_EN:    s_axi_rdata <= {30'h0, irq_en_q};
        `TMR8SP_OFF_WDT_COUNT: s_axi_rdata <= {24'h0, wdt_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TMR8SP_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_count_write;
    wr_count;
  endsequence

  // Timer-mode count write, the case with a fixed quiet window
  sequence s_timer_count_write;
    wr_count && !cs;
  endsequence

  // No further count write across two instruction cycles
  sequence s_two_cycles_quiet;
    (!wr_count) [*8];
  endsequence

  property p_write_loads;
    @(posedge aclk) disable iff (!aresetn)
      wr_count |=> count_q == $past(wdata_q[7:0]);
  endproperty
  a_write_loads: assert property (p_write_loads) else $error("count write not loaded");

  property p_holdoff;
    @(posedge aclk) disable iff (!aresetn)
      (s_count_write ##1 (!wr_count) [*6]) |-> ##1 count_q == $past(count_q, 6);
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("count moved during hold-off");

  // Pin mode may move on the seventh edge; timer mode stays put through the eighth
  property p_timer_holdoff;
    @(posedge aclk) disable iff (!aresetn)
      (s_timer_count_write ##1 s_two_cycles_quiet) |-> ##1 count_q == $past(count_q, 8);
  endproperty
  a_timer_holdoff: assert property (p_timer_holdoff) else $error("timer moved in hold-off");

  property p_timer_rate;
    @(posedge aclk) disable iff (!aresetn)
      (prescaler_assign && !cs && inhibit_q == 2'h0 && !sleep_mode && q4 && !wr_count)
        |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("undivided timer missed a cycle");

  property p_overflow_flag;
    @(posedge aclk) disable iff (!aresetn)
      (inc_now && count_q == 8'hff) |=> ovf_flag_q && count_q == 8'h00;
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("wrap did not set flag");

  property p_irq_request;
    @(posedge aclk) disable iff (!aresetn)
      (ovf_evt && ovf_ie_q && !wr_intctl) |=> timer_irq_request && ovf_flag_q;
  endproperty
  a_irq_request: assert property (p_irq_request) else $error("timer request mismatch");

  property p_sleep_freeze;
    @(posedge aclk) disable iff (!aresetn)
      (sleep_mode && !wr_count) |=> count_q == $past(count_q);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("counter moved in sleep");

  property p_counter_phase;
    @(posedge aclk) disable iff (!aresetn)
      (cs && $changed(count_q) && !$past(wr_count)) |-> $past(q2 || q4);
  endproperty
  a_counter_phase: assert property (p_counter_phase) else $error("pin count off phase");

  property p_presc_clear;
    @(posedge aclk) disable iff (!aresetn)
      ((!prescaler_assign && wr_count) || (prescaler_assign && watchdog_clear_instruction)) |=> presc_q == 8'h00;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_wdt_clear;
    @(posedge aclk) disable iff (!aresetn)
      watchdog_clear_instruction |=> wdt_q == 8'h00;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

  property p_presc_ratio;
    @(posedge aclk) disable iff (!aresetn)
      presc_hit |-> presc_q == ((prescaler_assign ? 8'h01 : 8'h02) << ps) - 8'h01 && (prescaler_assign || timer_evt);
  endproperty
  a_presc_ratio: assert property (p_presc_ratio) else $error("prescaler ratio wrong");

  property p_pin_edge;
    @(posedge aclk) disable iff (!aresetn)
      (prescaler_assign && cs && !sleep_mode && timer_evt) |-> (se ? $fell(external_count_input)
                                                      : $rose(external_count_input));
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("wrong pin edge counted");

  property p_wdt_timeout;
    @(posedge aclk) disable iff (!aresetn)
      (wdt_evt && !watchdog_clear_instruction && wdt_q == 8'hff)
        |=> watchdog_timeout && wdt_q == 8'h00 && stat_q[`TMR8SP_EVT_WDT_BIT];
  endproperty
  a_wdt_timeout: assert property (p_wdt_timeout) else $error("watchdog wrap not flagged");

endmodule

`default_nettype wire

// file: tb/tmr8sp_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
// Outside pulse source on the count pin, synchronous to the bench clock
module tmr8sp_pin_src (
  input  wire logic aclk, // Bench clock
  output logic      pin   // Count pin level
);
  // Driven pin, idle low between bursts
  initial pin = 1'b0;
  // Each level held half clocks, longer than one instruction cycle
  task automatic burst(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge aclk);
      pin <= 1'b1;
      repeat (half) @(posedge aclk);
      pin <= 1'b0;
    end
  endtask
  // Single level change, used to probe edge polarity
  task automatic lvl(input logic b);
    @(posedge aclk);
    pin <= b;
  endtask
endmodule
`default_nettype wire

// file: tb/tmr8sp_tb_top.sv
`include "tmr8sp_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tmr8sp_tb_top import tmr8sp_pkg::*; ;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, external_count_input, sleep_mode, watchdog_clock_tick;
  logic watchdog_clear_instruction, timer_irq_request, watchdog_timeout, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, keep;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  tmr8sp_byte_t opt [3] = '{8'h28, 8'h38, 8'h20};
  tmr8sp_byte_t ex [3]  = '{8'h07, 8'h06, 8'h03};
  int fail_count, checks_done;
  // Free-running clock, 4 ns period
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;
  tmr8sp_top tmr8sp_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_input, .sleep_mode,
    .watchdog_clock_tick, .watchdog_clear_instruction, .timer_irq_request,
    .watchdog_timeout, .irq);
  tmr8sp_pin_src tmr8sp_pin_src_i (.aclk(aclk), .pin(external_count_input));
  // ------
  // Bus tasks
  // ------
  // Handshakes judged at the negedge, so the next rising edge is the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic at, wt, ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      ad = ad | at;
      dd = dd | wt;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wq(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, v, rsp);
    `CHK(v, e)
  endtask
  // Timing slack of the bus makes exact counts unknowable, so a window
  task automatic rr(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    rd(a, v, rsp);
    `CHK((v >= lo && v <= hi), 1'b1)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wdclr();
    @(posedge aclk);
    watchdog_clear_instruction <= 1'b1;
    @(posedge aclk);
    watchdog_clear_instruction <= 1'b0;
  endtask
  task automatic wdtick(input int n);
    repeat (n) begin
      @(posedge aclk);
      watchdog_clock_tick <= 1'b1;
      @(posedge aclk);
      watchdog_clock_tick <= 1'b0;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------
  // Tests
  // ------
  // Hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #80000;
    fail_count++;
    test_done();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sleep_mode, watchdog_clock_tick, watchdog_clear_instruction} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`TMR8SP_OFF_OPTION, 32'h0000_00ff);
    rc(`TMR8SP_OFF_INTCTL, 32'h0);
    rc(`TMR8SP_OFF_IRQ_STAT, 32'h0);
    rd(8'h1c, v, rsp);
    `CHK(rsp, 2'h3)
    wr(8'h1c, 32'h1, rsp);
    `CHK(rsp, 2'h3)
    $display("test reset done");
    wq(`TMR8SP_OFF_OPTION, 32'h08);
    wq(`TMR8SP_OFF_COUNT, 32'h10);
    rc(`TMR8SP_OFF_COUNT, 32'h10);
    cyc(80);
    rr(`TMR8SP_OFF_COUNT, 32'h22, 32'h25);
    $display("test timer done");
    wdtick(5);
    rc(`TMR8SP_OFF_WDT_COUNT, 32'h5);
    wdclr();
    rc(`TMR8SP_OFF_WDT_COUNT, 32'h0);
    wq(`TMR8SP_OFF_OPTION, 32'h09);
    wdclr();
    wdtick(6);
    rc(`TMR8SP_OFF_WDT_COUNT, 32'h3);
    $display("test watchdog done");
    wq(`TMR8SP_OFF_COUNT, 32'hff);
    cyc(20);
    rc(`TMR8SP_OFF_INTCTL, 32'h04);
    @(negedge aclk);
    `CHK(timer_irq_request, 1'b0)
    wq(`TMR8SP_OFF_INTCTL, 32'h24);
    @(negedge aclk);
    `CHK(timer_irq_request, 1'b1)
    wq(`TMR8SP_OFF_IRQ_EN, 32'h1);
    @(negedge aclk);
    `CHK(irq, 1'b1)
    cyc(40);
    rc(`TMR8SP_OFF_INTCTL, 32'h24);
    wq(`TMR8SP_OFF_INTCTL, 32'h20);
    @(negedge aclk);
    `CHK(timer_irq_request, 1'b0)
    // Second wrap with the enable already set
    wq(`TMR8SP_OFF_COUNT, 32'hff);
    cyc(20);
    rc(`TMR8SP_OFF_INTCTL, 32'h24);
    @(negedge aclk);
    `CHK(timer_irq_request, 1'b1)
    wq(`TMR8SP_OFF_INTCTL, 32'h00);
    wq(`TMR8SP_OFF_IRQ_CLR, 32'h1);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    rc(`TMR8SP_OFF_IRQ_STAT, 32'h0);
    $display("test overflow done");
    sleep_mode <= 1'b1;
    rd(`TMR8SP_OFF_COUNT, keep, rsp);
    cyc(40);
    rc(`TMR8SP_OFF_COUNT, keep);
    sleep_mode <= 1'b0;
    $display("test sleep done");
    // Watchdog cleared before the prescaler changes hands
    wdclr();
    for (int c = 0; c < 3; c++) begin
      wq(`TMR8SP_OFF_OPTION, c);
      wq(`TMR8SP_OFF_COUNT, 32'h0);
      cyc(32 * (2 << c));
      rr(`TMR8SP_OFF_COUNT, 32'h6, 32'h9);
    end
    $display("test prescaler done");
    // Timer owns the prescaler, so every oscillator pulse advances the watchdog
    wdclr();
    wdtick(256);
    @(negedge aclk);
    `CHK(watchdog_timeout, 1'b1)
    @(negedge aclk);
    `CHK(watchdog_timeout, 1'b0)
    rc(`TMR8SP_OFF_IRQ_STAT, 32'h2);
    wq(`TMR8SP_OFF_IRQ_CLR, 32'h2);
    $display("test timeout done");
    // Undivided rising mode counts the final rise; falling mode and the divide-by-2 rising run do not
    for (int i = 0; i < 3; i++) begin
      wdclr();
      wq(`TMR8SP_OFF_COUNT, 32'h0);
      wq(`TMR8SP_OFF_OPTION, opt[i]);
      wq(`TMR8SP_OFF_COUNT, 32'h0);
      cyc(12);
      tmr8sp_pin_src_i.burst(6, 8);
      tmr8sp_pin_src_i.lvl(1'b1);
      cyc(12);
      rc(`TMR8SP_OFF_COUNT, {24'h0, ex[i]});
      tmr8sp_pin_src_i.lvl(1'b0);
    end
    $display("test counter done");
    test_done();
  end
endmodule
`default_nettype wire
